//--- message_capture_pkg.sv
/*
 * Constants, field layouts and types for the message capture receiver.
 * Assumes one system clock domain; the sender's port clock is sampled, not used as a clock.
 */
package message_capture_pkg;

    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] CTRL_OFS        = 8'h00;
    localparam logic [7:0] ACK_OFS         = 8'h04;
    localparam logic [7:0] STATUS_OFS      = 8'h08;
    localparam logic [7:0] BUF_A_START_OFS = 8'h0c;
    localparam logic [7:0] BUF_B_START_OFS = 8'h10;
    localparam logic [7:0] SIZE_OFS        = 8'h14;
    localparam logic [7:0] POINTER_OFS     = 8'h18;

    // Control register bits
    localparam int CTRL_ENABLE_BIT   = 0;
    localparam int CTRL_DONE_A_IE    = 1;
    localparam int CTRL_DONE_B_IE    = 2;
    localparam int CTRL_OVERRUN_IE   = 3;
    localparam int CTRL_OVERFLOW_IE  = 4;
    localparam int CTRL_FAULT_IE     = 5;
    localparam int CTRL_WIDTH        = 6;

    // Acknowledge register bits, write one to act
    localparam int BUFFER_A_RELEASE_BIT   = 0;
    localparam int BUFFER_B_RELEASE_BIT   = 1;
    localparam int EXCEEDED_CLEAR_BIT     = 2;
    localparam int BUSY_CLEAR_BIT         = 3;
    localparam int FAULT_CLEAR_BIT        = 4;

    // Status bits; event bits share positions with the enables minus one
    localparam int STAT_DONE_A   = 0;
    localparam int STAT_DONE_B   = 1;
    localparam int STAT_OVERRUN  = 2;
    localparam int STAT_OVERFLOW = 3;
    localparam int STAT_FAULT    = 4;
    localparam int EVENT_COUNT   = 5;
    localparam int STAT_ACTIVE   = 5;
    localparam int STAT_FREE_LO  = 6;
    localparam int STAT_STATE_LO = 8;

    // Reset values
    localparam logic [CTRL_WIDTH-1:0]  CTRL_RESET  = 6'h00;
    localparam logic [31:0]            WORD_RESET  = 32'h0000_0000;
    localparam logic [EVENT_COUNT-1:0] EVENT_RESET = 5'h00;

    // Input pin layout
    localparam int PIN_WIDTH   = 10;
    localparam int START_PIN   = 8;
    localparam int END_PIN     = 9;

    // Staging: two banks of 64 words of 32 bits
    localparam int BANK_COUNT  = 2;
    localparam int BANK_DEPTH  = 64;
    localparam int STAGE_DEPTH = BANK_COUNT * BANK_DEPTH;
    localparam int STAGE_AW    = 7;
    localparam logic [STAGE_AW:0] STAGE_FULL = 8'h80;

    // Buffer starts sit on this byte boundary
    localparam int ALIGN_BITS  = 6;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RECV = 2'b01,
        ST_STOP = 2'b10
    } cap_state_t;

    // One staged memory write
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
    } mem_word_t;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage : message_capture_pkg

//--- message_capture_receiver.sv
/*
 * Message receive path: samples the sender's byte port, packs bytes into words,
 * stages them in two 64-word banks and writes them out to memory in alternating buffers.
 * Assumes the sender's pins are asynchronous to sys_clk and its clock is far slower.
 */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/100ps

// Operation
// - Take message bytes from low eight pins, pack four per 32-bit word.
// - Reception begins only after a start event on pin 8.
// - Accept bytes until end strobe on pin 9 or active buffer full.
// - First byte is sampled on the port edge after the start edge.
// - Last byte is the one sampled with the end strobe high.
// - Switch to the other buffer on message end and on buffer fill.
// - Raise overrun when a message completes while the other buffer is unassigned.
// - Buffer full without end strobe raises overflow; enabled, it requests interrupt.
// - After overflow drop the message rest; resume in next buffer at next start.
// - Overflow flag clears only by writing one to its clear bit.
// - Bandwidth fault behaves as in raw capture.
// - Stage captured data in two internal banks of 64 words.
// - Full-resolution sizing: banks drain by highway transactions before the next fills.
// - Bandwidth fault loses data, stays set until cleared, address stays correct.
// - After overrun, capture continues on any buffer release; here it resumes at the next start only once the active buffer is released.
// - Buffer start and size are copied at buffer use; later writes wait.
// - Interrupt request stands while any enabled event is pending.
module message_capture_receiver (
    // Clock and reset
    input  wire  logic                                   sys_clk,
    input  wire  logic                                   reset,
    // Sender port
    input  wire  logic                                   sender_port_clock,
    input  wire  logic [message_capture_pkg::PIN_WIDTH-1:0] input_data_pins,
    // Register port
    input  wire  message_capture_pkg::reg_req_t          reg_req,
    output logic [31:0]                                  reg_rdata,
    // Memory write port
    output message_capture_pkg::mem_word_t               mem_word,
    output logic                                         mem_valid,
    input  wire  logic                                   mem_ready,
    // Host interrupt
    output logic                                         host_irq
);
    import message_capture_pkg::*;

    // Three-stage sampling of the asynchronous port
    logic [PIN_WIDTH-1:0]   pin_s1_r, pin_s2_r, pin_s3_r;
    logic                   clk_s1_r, clk_s2_r, clk_s3_r, clk_lvl_r;

    logic [CTRL_WIDTH-1:0]  ctrl_r;
    logic [EVENT_COUNT-1:0] event_r;
    logic [EVENT_COUNT-1:0] event_nxt;
    logic [31:0]            start_a_r, start_b_r, size_r;
    logic [31:0]            cur_base_r, cur_size_r, byte_cnt_r;
    logic [1:0]             free_r;
    logic                   active_r;
    cap_state_t             state_r, state_nxt;
    logic [31:0]            word_r;
    logic [3:0]             be_r;
    mem_word_t              stage_r [STAGE_DEPTH];
    logic [STAGE_AW-1:0]    wr_ptr_r, rd_ptr_r;
    logic [STAGE_AW:0]      fill_r;
    logic [31:0]            rdata_nxt;

    // Edge finding: a change counts once stages two and three agree
    wire        clk_agree  = (clk_s2_r == clk_s3_r);
    wire        port_rise  = clk_agree & clk_s3_r & ~clk_lvl_r;
    wire [7:0]  pin_byte   = pin_s3_r[7:0];
    wire        pin_start  = pin_s3_r[START_PIN];
    wire        pin_end    = pin_s3_r[END_PIN];
    wire        enabled    = ctrl_r[CTRL_ENABLE_BIT];

    // Register port decode
    wire        wr_ctrl    = reg_req.wr & (reg_req.addr == CTRL_OFS);
    wire        wr_ack     = reg_req.wr & (reg_req.addr == ACK_OFS);
    wire        wr_start_a = reg_req.wr & (reg_req.addr == BUF_A_START_OFS);
    wire        wr_start_b = reg_req.wr & (reg_req.addr == BUF_B_START_OFS);
    wire        wr_size    = reg_req.wr & (reg_req.addr == SIZE_OFS);
    wire        rel_a      = wr_ack & reg_req.wdata[BUFFER_A_RELEASE_BIT];
    wire        rel_b      = wr_ack & reg_req.wdata[BUFFER_B_RELEASE_BIT];
    wire [EVENT_COUNT-1:0] ev_clear = {wr_ack & reg_req.wdata[FAULT_CLEAR_BIT],
                                       wr_ack & reg_req.wdata[EXCEEDED_CLEAR_BIT],
                                       wr_ack & reg_req.wdata[BUSY_CLEAR_BIT],
                                       rel_b, rel_a};

    // Byte path
    // pointer per byte
    wire [31:0] byte_ptr   = cur_base_r + byte_cnt_r;
    wire [1:0]  lane       = byte_ptr[1:0];
    wire [31:0] cnt_inc    = byte_cnt_r + 32'h0000_0001;
    wire        take_byte  = enabled & port_rise & (state_r == ST_RECV);
    wire        msg_end    = take_byte & pin_end;
    wire        buf_full   = take_byte & ~pin_end & (cnt_inc == cur_size_r);
    wire        last_byte  = msg_end | buf_full;
    wire [31:0] word_nxt   = word_r | ({24'h00_0000, pin_byte} << {lane, 3'b000});
    wire [3:0]  be_nxt     = be_r | (4'h1 << lane);
    wire        push       = take_byte & ((lane == 2'b11) | last_byte);
    wire        stage_full = (fill_r == STAGE_FULL);
    wire        stage_wr   = push & ~stage_full;
    wire        stage_rd   = (fill_r != 8'h00) & (~mem_valid | mem_ready);
    wire        other_free = active_r ? free_r[0] : free_r[1];
    wire        act_free   = active_r ? free_r[1] : free_r[0];
    wire        start_evt  = enabled & port_rise & (state_r == ST_IDLE) & pin_start;
    wire        start_ok   = start_evt & act_free;
    wire        overrun    = (msg_end & ~other_free) | (start_evt & ~act_free);

    // Capture state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = ST_RECV;
                end
            end
            ST_RECV: begin
                if (msg_end) begin
                    state_nxt = other_free ? ST_IDLE : ST_STOP;
                end else if (buf_full) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_STOP: begin
                if (rel_a | rel_b) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (!enabled) begin
            state_nxt = ST_IDLE;
        end
    end

    // Sticky events; a set in the clearing cycle wins
    always_comb begin
        event_nxt = event_r & ~ev_clear;
        if (last_byte & ~active_r) begin
            event_nxt[STAT_DONE_A] = 1'b1;
        end
        if (last_byte & active_r) begin
            event_nxt[STAT_DONE_B] = 1'b1;
        end
        if (overrun) begin
            event_nxt[STAT_OVERRUN] = 1'b1;
        end
        if (buf_full) begin
            event_nxt[STAT_OVERFLOW] = 1'b1;
        end
        if (push & stage_full) begin
            event_nxt[STAT_FAULT] = 1'b1;
        end
    end

    // Read data mux
    always_comb begin
        rdata_nxt = WORD_RESET;
        if (reg_req.addr == CTRL_OFS) begin
            rdata_nxt = {26'h000_0000, ctrl_r};
        end else if (reg_req.addr == STATUS_OFS) begin
            rdata_nxt = {22'h00_0000, state_r, free_r, active_r, event_r};
        end else if (reg_req.addr == BUF_A_START_OFS) begin
            rdata_nxt = start_a_r;
        end else if (reg_req.addr == BUF_B_START_OFS) begin
            rdata_nxt = start_b_r;
        end else if (reg_req.addr == SIZE_OFS) begin
            rdata_nxt = size_r;
        end else if (reg_req.addr == POINTER_OFS) begin
            rdata_nxt = byte_ptr;
        end
    end

    // Pin stages carry no reset; the sender stays quiet until they have filled
    always_ff @(posedge sys_clk) begin
        pin_s1_r <= input_data_pins;
        pin_s2_r <= pin_s1_r;
        pin_s3_r <= pin_s2_r;
    end

    // Clock level follows only once stages two and three agree
    always_ff @(posedge sys_clk) begin
        clk_s1_r  <= sender_port_clock;
        clk_s2_r  <= clk_s1_r;
        clk_s3_r  <= clk_s2_r;
        clk_lvl_r <= clk_agree ? clk_s3_r : clk_lvl_r;
    end

    // Control and buffer set-up registers
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_r    <= CTRL_RESET;
            start_a_r <= WORD_RESET;
            start_b_r <= WORD_RESET;
            size_r    <= WORD_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= reg_req.wdata[CTRL_WIDTH-1:0];
            end
            if (wr_start_a) begin
                start_a_r <= {reg_req.wdata[31:ALIGN_BITS], 6'h00};
            end
            if (wr_start_b) begin
                start_b_r <= {reg_req.wdata[31:ALIGN_BITS], 6'h00};
            end
            if (wr_size) begin
                size_r <= reg_req.wdata;
            end
        end
    end

    // Host flags and interrupt
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            event_r  <= EVENT_RESET;
            host_irq <= 1'b0;
        end else begin
            event_r  <= event_nxt;
            host_irq <= |(event_nxt & ctrl_r[CTRL_WIDTH-1:1]);
        end
    end

    // Read data stands for one cycle only, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= WORD_RESET;
        end else begin
            reg_rdata <= reg_req.rd ? rdata_nxt : WORD_RESET;
        end
    end

    // Capture state and private buffer copies
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r    <= ST_IDLE;
            cur_base_r <= WORD_RESET;
            cur_size_r <= WORD_RESET;
            byte_cnt_r <= WORD_RESET;
        end else begin
            state_r <= state_nxt;
            if (start_ok) begin
                cur_base_r <= active_r ? start_b_r : start_a_r;
                cur_size_r <= size_r;
                byte_cnt_r <= WORD_RESET;
            end else if (take_byte) begin
                byte_cnt_r <= cnt_inc;
            end
        end
    end

    // Word packing; a pushed word leaves all lanes empty for the next one
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            word_r <= WORD_RESET;
            be_r   <= 4'h0;
        end else if (push | start_ok) begin
            word_r <= WORD_RESET;
            be_r   <= 4'h0;
        end else if (take_byte) begin
            word_r <= word_nxt;
            be_r   <= be_nxt;
        end
    end

    // Active buffer flips at every buffer end, by end strobe or by fill
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            active_r <= 1'b0;
        end else if (last_byte) begin
            active_r <= ~active_r;
        end
    end

    // One free bit per buffer; release wins over use in the same cycle
    for (genvar b = 0; b < $bits(free_r); b++) begin : g_free
        wire used = last_byte & (active_r == 1'(b));
        wire rel  = (b == 0) ? rel_a : rel_b;
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                free_r[b] <= 1'b0;
            end else begin
                free_r[b] <= rel | (free_r[b] & ~used);
            end
        end
    end

    // two staging banks
    // Entries carry no reset; only the pointers say what is valid
    always_ff @(posedge sys_clk) begin
        if (stage_wr) begin
            stage_r[wr_ptr_r] <= {{byte_ptr[31:2], 2'b00}, word_nxt, be_nxt};
        end
    end

    // Write pointer; a dropped word still lets the byte address run on
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_r <= 7'h00;
        end else if (stage_wr) begin
            wr_ptr_r <= wr_ptr_r + 7'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rd_ptr_r  <= 7'h00;
            mem_valid <= 1'b0;
            mem_word  <= '0;
        end else if (stage_rd) begin
            mem_word  <= stage_r[rd_ptr_r];
            rd_ptr_r  <= rd_ptr_r + 7'h01;
            mem_valid <= 1'b1;
        end else if (mem_ready) begin
            mem_valid <= 1'b0;
        end
    end

    // Fill count is one bit wider than the pointers so full and empty differ
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            fill_r <= 8'h00;
        end else begin
            fill_r <= fill_r + {7'h00, stage_wr} - {7'h00, stage_rd};
        end
    end

endmodule : message_capture_receiver

//--- message_capture_properties.sv
/*
 * Port checker for the message capture receiver, bound into every instance.
 * Assumes one sys_clk domain and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module message_capture_properties (
    // Clock and reset
    input wire logic                                   sys_clk,
    input wire logic                                   reset,
    // Sender port
    input wire logic                                   sender_port_clock,
    input wire logic [message_capture_pkg::PIN_WIDTH-1:0] input_data_pins,
    // Register port
    input wire message_capture_pkg::reg_req_t          reg_req,
    input wire logic [31:0]                            reg_rdata,
    // Memory port and interrupt
    input wire message_capture_pkg::mem_word_t         mem_word,
    input wire logic                                   mem_valid,
    input wire logic                                   mem_ready,
    input wire logic                                   host_irq
);
    import message_capture_pkg::*;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_MEM_HOLD: assert property (
        mem_valid && !mem_ready |=> mem_valid && $stable(mem_word)) else $error("memory word moved while stalled");
    AST_WORD_ALIGN: assert property (
        mem_valid |-> mem_word.addr[1:0] == 2'b00) else $error("memory word not word aligned");
    AST_LOW_LANES: assert property (
        mem_valid |-> mem_word.be inside {4'h1, 4'h3, 4'h7, 4'hf}) else $error("byte lanes not packed from lane 0");
    // Reset itself is the cause here, so no disable
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        reset |=> !host_irq && !mem_valid && reg_rdata == 32'h0) else $error("outputs active after reset");
    AST_IRQ_MASK: assert property (
        reg_req.wr && reg_req.addr == CTRL_OFS && reg_req.wdata[5:1] == 5'h00 |-> ##2 !host_irq)
        else $error("interrupt stands with all enables off");
    AST_IRQ_FALL: assert property (
        $fell(host_irq) |-> $past(reg_req.wr) || $past(reg_req.wr, 2) || $past(reset))
        else $error("interrupt fell without a register write");
    AST_ACK_READS_ZERO: assert property (
        reg_req.rd && reg_req.addr == ACK_OFS |=> reg_rdata == 32'h0) else $error("acknowledge read not zero");
    AST_RDATA_IDLE: assert property (
        !reg_req.rd |=> reg_rdata == 32'h0) else $error("read data outside read slot");

    COV_MEM_XFER: cover property (mem_valid && mem_ready);
    COV_PARTIAL: cover property (mem_valid && mem_word.be != 4'hf);
    COV_IRQ: cover property ($rose(host_irq));
endmodule : message_capture_properties

bind message_capture_receiver message_capture_properties chk (
    .sys_clk(sys_clk), .reset(reset), .sender_port_clock(sender_port_clock),
    .input_data_pins(input_data_pins), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .mem_word(mem_word), .mem_valid(mem_valid), .mem_ready(mem_ready), .host_irq(host_irq));

//--- msg_sender.sv
/*
 * Behavioural byte-port message transmitter.
 * Assumes the receiver samples its 125 ns port clock; clock stands low between messages.
 */
`timescale 1ns/100ps

module msg_sender (
    // Sender pins
    output logic                                          sender_port_clock,
    output logic [message_capture_pkg::PIN_WIDTH-1:0]     input_data_pins
);
    import message_capture_pkg::*;

    logic [7:0] last;

    initial begin
        sender_port_clock = 1'b0;
        input_data_pins   = '0;
        last              = 8'h00;
    end

    task automatic tick();
        #62.5 sender_port_clock = 1'b1;
        #62.5 sender_port_clock = 1'b0;
    endtask : tick

    task automatic send(input int n, input logic [7:0] first, input logic message_end_strobe);
        int k;
        input_data_pins = {2'b01, ~first};
        tick();
        for (k = 0; k < n; k++) begin
            last = first + 8'(k);
            input_data_pins = {message_end_strobe && k == n - 1, 1'b0, last};
            tick();
        end
        // Released lines show the inverse, never the held byte
        input_data_pins = {2'b00, ~last};
    endtask : send
endmodule : msg_sender

//--- message_capture_receiver_tb.sv
/*
 * Self-checking bench: set-up, capture, overflow, overrun, interrupt mask.
 * Assumes msg_sender on the pins and a memory that stalls every other cycle.
 */
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end

module message_capture_receiver_tb;
    import message_capture_pkg::*;

    logic                 sys_clk;
    logic                 reset;
    logic                 pclk;
    logic [PIN_WIDTH-1:0] pins;
    reg_req_t             req;
    logic [31:0]          rdata;
    mem_word_t            mword;
    logic                 mvalid;
    logic                 mready;
    logic                 irq;
    logic [31:0]          rv;
    mem_word_t            words[$];
    int                   err_total;
    int                   checks;

    msg_sender tx (.sender_port_clock(pclk), .input_data_pins(pins));
    message_capture_receiver DUT (
        .sys_clk(sys_clk), .reset(reset), .sender_port_clock(pclk), .input_data_pins(pins),
        .reg_req(req), .reg_rdata(rdata), .mem_word(mword), .mem_valid(mvalid),
        .mem_ready(mready), .host_irq(irq));

    always #2 sys_clk = ~sys_clk;

    // Stalling memory keeps the hold path busy
    // short memory latency
    always @(posedge sys_clk) begin
        if (mvalid && mready) begin
            words.push_back(mword);
        end
        mready <= ~mready;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= {a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        req <= {a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge sys_clk);
        req <= '0;
        #1 rv = rdata;
    endtask : rd

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic wait_words(input int n);
        int t;
        for (t = 0; t < 3000 && words.size() < n; t++) @(posedge sys_clk);
        if (words.size() < n) begin
            `CHK(words.size(), n)
            end_sim();
        end
    endtask : wait_words

    task automatic exp_msg(input logic [7:0] f, input int n, input logic [31:0] base);
        mem_word_t   w;
        logic [3:0]  be;
        logic [31:0] d;
        logic [31:0] m;
        int          i;
        int          k;
        for (i = 0; i < (n + 3) / 4; i++) begin
            w = words.pop_front();
            be = (n - 4 * i >= 4) ? 4'hf : 4'((1 << (n - 4 * i)) - 1);
            for (k = 0; k < 4; k++) begin
                d[8*k +: 8] = f + 8'(4 * i + k);
                m[8*k +: 8] = {8{be[k]}};
            end
            `CHK(w.addr, base + 32'(4 * i))
            `CHK(w.be, be)
            `CHK(w.data & m, d & m)
        end
    endtask : exp_msg

    task automatic t_regs();
        rd(CTRL_OFS);
        `CHK(rv, 32'h0)
        rd(8'h40);
        `CHK(rv, 32'h0)
        wr(BUF_A_START_OFS, 32'h13f);
        rd(BUF_A_START_OFS);
        `CHK(rv, 32'h100)
        wr(BUF_B_START_OFS, 32'h200);
        wr(SIZE_OFS, 32'h8);
        wr(ACK_OFS, 32'h3);
        rd(ACK_OFS);
        `CHK(rv, 32'h0)
        wr(CTRL_OFS, 32'h3f);
        rd(STATUS_OFS);
        `CHK(rv, 32'h0c0)
        $display("test regs done");
    endtask : t_regs

    task automatic t_msg();
        tx.send(7, 8'h10, 1'b1);
        wait_words(2);
        exp_msg(8'h10, 7, 32'h100);
        rd(STATUS_OFS);
        `CHK(rv & 32'hff, 32'h0a1)
        `CHK(irq, 1'b1)
        rd(POINTER_OFS);
        `CHK(rv, 32'h107)
        $display("test message done");
    endtask : t_msg

    task automatic t_overflow();
        tx.send(10, 8'h40, 1'b0);
        wait_words(2);
        exp_msg(8'h40, 8, 32'h200);
        repeat (50) @(posedge sys_clk);
        `CHK(words.size(), 0)
        rd(STATUS_OFS);
        `CHK(rv & 32'hfb, 32'h0b)
        wr(ACK_OFS, 32'h10);
        rd(STATUS_OFS);
        `CHK(rv[STAT_OVERFLOW], 1'b1)
        wr(ACK_OFS, 32'h4);
        rd(STATUS_OFS);
        `CHK(rv[STAT_OVERFLOW], 1'b0)
        $display("test overflow done");
    endtask : t_overflow

    task automatic t_overrun();
        tx.send(3, 8'h70, 1'b1);
        repeat (30) @(posedge sys_clk);
        `CHK(words.size(), 0)
        rd(STATUS_OFS);
        `CHK(rv[STAT_OVERRUN], 1'b1)
        wr(BUF_A_START_OFS, 32'h140);
        wr(ACK_OFS, 32'h1);
        tx.send(2, 8'h80, 1'b1);
        wait_words(1);
        exp_msg(8'h80, 2, 32'h140);
        rd(STATUS_OFS);
        `CHK(rv[STAT_OVERRUN], 1'b1)
        $display("test overrun done");
    endtask : t_overrun

    task automatic irq_is(input logic v);
        repeat (3) @(posedge sys_clk);
        #1 `CHK(irq, v)
    endtask : irq_is

    task automatic t_irq();
        wr(CTRL_OFS, 32'h01);
        irq_is(1'b0);
        wr(CTRL_OFS, 32'h3f);
        irq_is(1'b1);
        wr(ACK_OFS, 32'h1f);
        irq_is(1'b0);
        $display("test interrupt done");
    endtask : t_irq

    initial begin
        sys_clk   = 1'b0;
        reset     = 1'b1;
        req       = '0;
        mready    = 1'b0;
        err_total = 0;
        checks    = 0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        // Synchroniser stages are not reset
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_msg();
        t_overflow();
        t_overrun();
        t_irq();
        end_sim();
    end
endmodule : message_capture_receiver_tb
